/* design/pcg_consts.vh */
// constants for the peripheral clock gate bank
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH
`define PCG_OFF_RUN         12'h0104
`define PCG_OFF_SLEEP       12'h0114
`define PCG_OFF_DEEP        12'h0124
`define PCG_OFF_CFG         12'h0060
`define PCG_OFF_INT_STAT    12'h0200
`define PCG_OFF_INT_MASK    12'h0204
`define PCG_BIT_TMR2        18
`define PCG_BIT_TMR1        17
`define PCG_BIT_TMR0        16
`define PCG_BIT_TWI         12
`define PCG_BIT_SSP         4
`define PCG_BIT_ASP         0
`define PCG_BIT_AUTO        0
`define PCG_STAT_MSB        5
`define PCG_PAD31           31'h0000_0000
`define PCG_PAD26           26'h000_0000
`define PCG_ADDR_ZERO       12'h000
`define PCG_STRB_ZERO       4'h0
`define PCG_WMASK           32'h0007_1011
`define PCG_RESET_VAL       32'h0000_0000
`define PCG_ZERO32          32'h0000_0000
`define PCG_UNITS           6
`define PCG_UNIT_ZERO       6'h00
`define PCG_PWR_RUN         2'h0
`define PCG_PWR_SLEEP       2'h1
`define PCG_PWR_DEEP        2'h2
`define PCG_RESP_OKAY       2'h0
`define PCG_RESP_SLVERR     2'h2
`endif

/* design/pcg_clock_gate_bank.v */
// peripheral clock gate bank with axi4-lite registers and fault flags
//
// Operation
// - bit 18 enables the clock of timer two.
// - bit 17 enables the clock of timer one.
// - bit 16 enables the clock of timer zero.
// - bit 12 enables the clock of the two-wire serial port.
// - bit 4 enables the clock of the synchronous serial port.
// - bit 0 enables the clock of the asynchronous serial port.
// - one supplies the unit clock, zero stops it and holds unit disabled.
// - any access to an unclocked unit gets a bus fault answer.
// - all enable bits clear to zero at reset.
// - reserved bits read zero, ignore writes; software preserves them.
// - positions with no unit are read-only reserved bits.
// - run, sleep and deep-sleep copies; applied copy follows power state.
// - sleep copies govern only when auto clock gating bit is set.
// - sleep copy is read-write at offset 0x114, reset zero.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pcg_consts.vh"

module pcg_clock_gate_bank (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address and data
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // power state, same clock domain
  input  wire [1:0]  power_state,
  // unit bus access attempts, same clock domain, one bit per unit
  input  wire [5:0]  unit_access,
  output wire [5:0]  unit_bus_fault,
  // gated unit clocks and enables
  output wire        gp_counter_two_clock,
  output wire        gp_counter_one_clock,
  output wire        gp_counter_zero_clock,
  output wire        two_wire_port_clock,
  output wire        sync_serial_port_clock,
  output wire        async_serial_port_clock,
  output wire [5:0]  unit_enable,
  // interrupt
  output wire        irq
);

  // stored enable copies and configuration
  reg  [31:0] run_q;
  reg  [31:0] sleep_q;
  reg  [31:0] deep_q;
  reg         auto_gate_q;

  // fault flags and their mask
  reg  [5:0]  stat_q;
  reg  [5:0]  mask_q;

  // effective enable, moved only while the clock is low
  reg  [5:0]  lat_q;

  // write channel holding registers
  reg  [11:0] awaddr_q;
  reg         aw_have_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_have_q;

  // combinational selections
  reg  [31:0] eff_sel;
  reg  [31:0] rd_val;
  reg         rd_hit;
  reg  [1:0]  wr_resp;

  // handshake and write decode
  wire        aw_take;
  wire        w_take;
  wire        ar_take;
  wire        b_done;
  wire        r_done;
  wire        wr_go;
  wire        lane0;
  wire        wr_run;
  wire        wr_sleep;
  wire        wr_deep;
  wire        wr_cfg;
  wire        wr_stat;
  wire        wr_mask_reg;
  wire [31:0] wr_mask;
  wire [31:0] wr_keep;
  wire [31:0] wr_val;
  wire [5:0]  en_now;
  wire [5:0]  wr_clr;

  // a held item or a pending answer blocks the next one
  // only one write and one read are ever in flight, so no queue is needed
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign b_done        = s_axi_bvalid && s_axi_bready;
  assign r_done        = s_axi_rvalid && s_axi_rready;
  // both halves in hand and no answer pending
  assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;

  // write decode on the held address
  assign lane0       = wstrb_q[0];
  assign wr_run      = wr_go && (awaddr_q == `PCG_OFF_RUN);
  assign wr_sleep    = wr_go && (awaddr_q == `PCG_OFF_SLEEP);
  assign wr_deep     = wr_go && (awaddr_q == `PCG_OFF_DEEP);
  assign wr_cfg      = wr_go && (awaddr_q == `PCG_OFF_CFG);
  assign wr_stat     = wr_go && (awaddr_q == `PCG_OFF_INT_STAT);
  assign wr_mask_reg = wr_go && (awaddr_q == `PCG_OFF_INT_MASK);
  assign wr_mask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  // reserved and unit-less bits never store
  assign wr_keep     = wr_mask & `PCG_WMASK;
  assign wr_val      = wdata_q & wr_keep;

  // pick the copy that follows the power state
  always @* begin
    eff_sel = run_q;
    // sleep copies only under auto gating
    if (auto_gate_q) begin
      case (power_state)
        `PCG_PWR_SLEEP: eff_sel = sleep_q;
        `PCG_PWR_DEEP:  eff_sel = deep_q;
        default:        eff_sel = run_q;
      endcase
    end else begin
      // run copy stays applied in every state
      eff_sel = run_q;
    end
  end

  assign en_now[5] = eff_sel[`PCG_BIT_TMR2];
  assign en_now[4] = eff_sel[`PCG_BIT_TMR1];
  assign en_now[3] = eff_sel[`PCG_BIT_TMR0];
  assign en_now[2] = eff_sel[`PCG_BIT_TWI];
  assign en_now[1] = eff_sel[`PCG_BIT_SSP];
  assign en_now[0] = eff_sel[`PCG_BIT_ASP];

  // enable moves on the falling edge only
  // the and gate below then never sees a change while the clock is high,
  // so no pulse is cut short; the cost is half a cycle of enable delay
  always @(negedge aclk) begin
    if (!aresetn) begin
      lat_q <= `PCG_UNIT_ZERO;
    end else begin
      lat_q <= en_now;
    end
  end

  assign unit_enable             = lat_q;
  assign gp_counter_two_clock    = aclk & lat_q[5];
  assign gp_counter_one_clock    = aclk & lat_q[4];
  assign gp_counter_zero_clock   = aclk & lat_q[3];
  assign two_wire_port_clock     = aclk & lat_q[2];
  assign sync_serial_port_clock  = aclk & lat_q[1];
  assign async_serial_port_clock = aclk & lat_q[0];

  // access to a unit whose clock is off right now faults
  // judged on the latched enable, which is what the unit really gets
  assign unit_bus_fault = unit_access & ~lat_q;
  assign irq            = |(stat_q & mask_q);
  // status clear uses byte lane zero only
  assign wr_clr = (wr_stat && lane0) ? wdata_q[`PCG_STAT_MSB:0] : `PCG_UNIT_ZERO;

  // read decode; unmapped offsets answer with an error and zero data
  always @* begin
    rd_hit = 1'b1;
    rd_val = `PCG_ZERO32;
    case (s_axi_araddr)
      `PCG_OFF_RUN:      rd_val = run_q;
      `PCG_OFF_SLEEP:    rd_val = sleep_q;
      `PCG_OFF_DEEP:     rd_val = deep_q;
      `PCG_OFF_CFG:      rd_val = {`PCG_PAD31, auto_gate_q};
      `PCG_OFF_INT_STAT: rd_val = {`PCG_PAD26, stat_q};
      `PCG_OFF_INT_MASK: rd_val = {`PCG_PAD26, mask_q};
      default:           rd_hit = 1'b0;
    endcase
  end

  // write response code from the held address
  always @* begin
    wr_resp = `PCG_RESP_OKAY;
    case (awaddr_q)
      `PCG_OFF_RUN:      wr_resp = `PCG_RESP_OKAY;
      `PCG_OFF_SLEEP:    wr_resp = `PCG_RESP_OKAY;
      `PCG_OFF_DEEP:     wr_resp = `PCG_RESP_OKAY;
      `PCG_OFF_CFG:      wr_resp = `PCG_RESP_OKAY;
      `PCG_OFF_INT_STAT: wr_resp = `PCG_RESP_OKAY;
      `PCG_OFF_INT_MASK: wr_resp = `PCG_RESP_OKAY;
      default:           wr_resp = `PCG_RESP_SLVERR;
    endcase
  end

  // write address holding register
  // awready drops while held, so a take and a commit never meet
  always @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q  <= `PCG_ADDR_ZERO;
      aw_have_q <= 1'b0;
    end else if (aw_take) begin
      awaddr_q  <= s_axi_awaddr;
      aw_have_q <= 1'b1;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  // write data holding register
  always @(posedge aclk) begin
    if (!aresetn) begin
      wdata_q  <= `PCG_ZERO32;
      wstrb_q  <= `PCG_STRB_ZERO;
      w_have_q <= 1'b0;
    end else if (w_take) begin
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
      w_have_q <= 1'b1;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  // write response channel, one cycle after commit
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PCG_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_resp;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, answer on the edge after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `PCG_ZERO32;
      s_axi_rresp  <= `PCG_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
    end else if (r_done) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // every copy clears, so all units start unclocked
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= `PCG_RESET_VAL;
    end else if (wr_run) begin
      run_q <= (run_q & ~wr_keep) | wr_val;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      sleep_q <= `PCG_RESET_VAL;
    end else if (wr_sleep) begin
      sleep_q <= (sleep_q & ~wr_keep) | wr_val;
    end
  end

  // deep-sleep copy, same layout
  always @(posedge aclk) begin
    if (!aresetn) begin
      deep_q <= `PCG_RESET_VAL;
    end else if (wr_deep) begin
      deep_q <= (deep_q & ~wr_keep) | wr_val;
    end
  end

  // auto gating select, lane zero only
  always @(posedge aclk) begin
    if (!aresetn) begin
      auto_gate_q <= 1'b0;
    end else if (wr_cfg && lane0) begin
      auto_gate_q <= wdata_q[`PCG_BIT_AUTO];
    end
  end

  // interrupt mask, lane zero only
  always @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= `PCG_UNIT_ZERO;
    end else if (wr_mask_reg && lane0) begin
      mask_q <= wdata_q[`PCG_STAT_MSB:0];
    end
  end

  // fault flags: a fault in the clearing cycle wins,
  // so software never loses an event it has not yet seen
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= `PCG_UNIT_ZERO;
    end else begin
      stat_q <= (stat_q & ~wr_clr) | unit_bus_fault;
    end
  end

endmodule // pcg_clock_gate_bank

/* verification/pcg_unit_model.sv */
// far-side unit model: drives bus access attempts
`timescale 1ns/10ps
module pcg_unit_model (
  // clock and request
  input  wire       aclk,
  input  wire [5:0] want,
  // attempts seen by the gate bank
  output reg  [5:0] unit_access
);
  initial unit_access = 6'h00;
  always @(posedge aclk) unit_access <= want;
endmodule // pcg_unit_model

/* verification/pcg_checker_assertions.sv */
// port checker for the clock gate bank
`timescale 1ns/10ps
module pcg_checker (
  // clock, reset, bus
  input wire        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire        s_axi_arready, s_axi_rvalid,
  input wire [1:0]  s_axi_bresp,
  input wire [31:0] s_axi_rdata,
  // units
  input wire [5:0]  unit_access, unit_bus_fault, unit_enable,
  input wire        gp_counter_two_clock, gp_counter_one_clock, gp_counter_zero_clock,
  input wire        two_wire_port_clock, sync_serial_port_clock, async_serial_port_clock
);
  wire [5:0] clks = {gp_counter_two_clock, gp_counter_one_clock, gp_counter_zero_clock,
    two_wire_port_clock, sync_serial_port_clock, async_serial_port_clock};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    ##[1:2] s_axi_bvalid;
  endsequence
  chk_write_answer: assert property (wr_taken |-> wr_answer) else $error("late bvalid");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late rvalid");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
  chk_reserved_zero: assert property (s_axi_rvalid |-> !(s_axi_rdata & 32'hfff8_efc0))
    else $error("reserved bit set");
  chk_fault_map: assert property (unit_bus_fault == (unit_access & ~unit_enable))
    else $error("fault mismatch");
  // gated clocks are high only while enabled
  chk_gate_follow: assert property (@(negedge aclk) clks == unit_enable)
    else $error("clock gate wrong");
  chk_reset_clear: assert property ($rose(aresetn) |-> !unit_enable && !s_axi_bvalid)
    else $error("enable after reset");
endmodule // pcg_checker
bind pcg_clock_gate_bank pcg_checker pcg_checker_inst (.*);

/* verification/pcg_clock_gate_bank_bench.sv */
// self-checking bench for the clock gate bank
`timescale 1ns/10ps
`include "pcg_consts.vh"
module pcg_clock_gate_bank_bench;
  reg         aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0;
  reg  [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg  [31:0] s_axi_wdata = 0, rd_q;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg  [1:0]  power_state = 0, resp;
  reg  [5:0]  want = 0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [5:0]  unit_access, unit_bus_fault, unit_enable;
  wire        gp_counter_two_clock, gp_counter_one_clock, gp_counter_zero_clock;
  wire        two_wire_port_clock, sync_serial_port_clock, async_serial_port_clock;
  integer     bad_count = 0, compares = 0;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
  always #5 aclk = ~aclk;
  pcg_clock_gate_bank pcg_clock_gate_bank_inst (.*);
  pcg_unit_model pcg_unit_model_inst (.aclk(aclk), .want(want), .unit_access(unit_access));
  // ready and valid are read at the falling edge, acted on at the rising one
  task wr(input [11:0] a, input [31:0] d);
    reg ta, tw, tb;
    begin
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      tb = 0;
      while (!tb) begin
        @(negedge aclk);
        {ta, tw, tb, resp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
        @(posedge aclk);
        if (ta) s_axi_awvalid <= 0;
        if (tw) s_axi_wvalid <= 0;
      end
      s_axi_bready <= 0;
    end
  endtask
  task rd(input [11:0] a);
    reg ta, t;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      t = 0;
      while (!t) begin
        @(negedge aclk);
        {ta, t, rd_q, resp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
        @(posedge aclk);
        if (ta) s_axi_arvalid <= 0;
      end
      s_axi_rready <= 0;
    end
  endtask
  task t_bits;
    integer i;
    integer b [0:5];
    begin
      b = '{0, 4, 12, 16, 17, 18};
      `CHK(unit_enable, 6'h00)
      for (i = 0; i < 6; i++) begin
        wr(`PCG_OFF_RUN, 32'h0000_0001 << b[i]);
        `CHK(unit_enable, 6'h01 << i)
      end
      wr(`PCG_OFF_RUN, 32'hffff_ffff);
      rd(`PCG_OFF_RUN);
      `CHK(rd_q, 32'h0007_1011)
    end
  endtask
  task t_fault;
    begin
      wr(`PCG_OFF_RUN, 32'h0000_0001);
      wr(`PCG_OFF_INT_MASK, 32'h0000_003f);
      want <= 6'h3f;
      @(posedge aclk);
      @(negedge aclk);
      `CHK(unit_bus_fault, 6'h3e)
      @(posedge aclk) want <= 6'h00;
      // flags are registered, so irq rises one edge after the fault
      @(negedge aclk);
      `CHK(irq, 1'b1)
      rd(`PCG_OFF_INT_STAT);
      `CHK(rd_q, 32'h0000_003e)
      wr(`PCG_OFF_INT_STAT, 32'h0000_003e);
      `CHK(irq, 1'b0)
    end
  endtask
  task t_sleep;
    begin
      rd(`PCG_OFF_SLEEP);
      `CHK(rd_q, 32'h0000_0000)
      wr(`PCG_OFF_RUN, 32'h0007_1011);
      wr(`PCG_OFF_SLEEP, 32'h0000_0010);
      power_state <= `PCG_PWR_SLEEP;
      rd(`PCG_OFF_SLEEP);
      `CHK(rd_q, 32'h0000_0010)
      `CHK(unit_enable, 6'h3f)
      wr(`PCG_OFF_CFG, 32'h0000_0001);
      @(posedge aclk);
      `CHK(unit_enable, 6'h02)
      power_state <= `PCG_PWR_DEEP;
      @(posedge aclk);
      `CHK(unit_enable, 6'h00)
      rd(12'h300);
      `CHK(resp, `PCG_RESP_SLVERR)
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    t_bits;
    t_fault;
    t_sleep;
    tally_and_finish;
  end
  // about 80 bus cycles expected; generous bound
  initial begin
    repeat (3000) @(posedge aclk);
    bad_count++;
    tally_and_finish;
  end
endmodule // pcg_clock_gate_bank_bench
